/* File: logic/rotate_and_return_unit.sv */
// execution unit for the four rotates and the subroutine exit
//
// Summary of operation
// - Subroutine exit loads program counter from stack word; stack pointer grows by two in the same cycle.
// - Byte at stack pointer is the high byte, next byte the low byte.
// - Fetch resumes at restored counter; exit takes nine cycles, flags untouched.
// - Rotate left moves bit 7 to bit 0; opcodes 90/91, four cycles for 90, five for indirect 91.
// - Rotate left via carry: old carry to bit 0, bit 7 to carry.
// - Rotate right moves bit 0 to bit 7; opcodes E0/E1, four cycles for E0, five for indirect E1.
// - Rotate right via carry: old carry to bit 7, bit 0 to carry.
// - Left rotates set carry exactly when the old bit 7 was one.
// - Right rotates set carry exactly when the old bit 0 was one.
// - Zero flag follows the result; decimal-adjust and half-carry flags stay.
// - Sign flag takes bit 7 of the result.
// - Overflow flag set when bit 7 changed across the rotation.
`timescale 1ns/1ps
`include "rotate_return_params.svh"
module rotate_and_return_unit (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        issue,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  operandAddr,
    input  wire logic [7:0]  regReadData,
    input  wire logic [7:0]  flagsIn,
    input  wire logic [7:0]  memReadData,
    output logic      [7:0]  regAddr,
    output logic             regRead,
    output logic             regWrite,
    output logic      [7:0]  regWriteData,
    output logic             flagsWrite,
    output logic      [7:0]  flagsOut,
    output logic      [15:0] memAddr,
    output logic             memRead,
    output logic      [15:0] programCounter,
    output logic      [15:0] stackPointer,
    output logic             fetchRequest,
    output logic             busy,
    output logic             illegalOpcode
);
    import rotate_return_pkg::*;

    typedef enum logic [5:0] {
        ST_IDLE     = 6'b000001,
        ST_POINTER  = 6'b000010,
        ST_OPERAND  = 6'b000100,
        ST_WRITE    = 6'b001000,
        ST_RETURN   = 6'b010000,
        ST_FETCH    = 6'b100000
    } state_type;

    state_type     state_q, state_d;
    rotate_op_type op_q;
    logic          indirect_q;
    logic [7:0]    addr_q;
    logic [7:0]    operand_q;
    logic [7:0]    flags_q;
    logic [15:0]   pc_q;
    logic [15:0]   sp_q;
    logic [2:0]    cyc_q;
    logic [7:0]    resultData_q;
    logic [7:0]    flagsOut_q;
    logic          regWrite_q;
    logic          flagsWrite_q;
    logic          illegal_q;

    rotate_bus_if  rotBus();

    // opcode decode
    wire isRl    = (opcode == `OPC_RL_DIR)  || (opcode == `OPC_RL_IND);
    wire isRlc   = (opcode == `OPC_RLC_DIR) || (opcode == `OPC_RLC_IND);
    wire isRr    = (opcode == `OPC_RR_DIR)  || (opcode == `OPC_RR_IND);
    wire isRrc   = (opcode == `OPC_RRC_DIR) || (opcode == `OPC_RRC_IND);
    wire isRet   = (opcode == `OPC_RET);
    wire isRot   = isRl || isRlc || isRr || isRrc;
    wire isInd   = opcode[0];
    wire accept  = issue && (state_q == ST_IDLE);

    rotate_op_type decodedOp;
    assign decodedOp = isRl  ? OP_ROTATE_LEFT :
                       isRlc ? OP_ROTATE_LEFT_VIA_CARRY :
                       isRr  ? OP_ROTATE_RIGHT :
                       isRrc ? OP_ROTATE_RIGHT_VIA_CARRY : OP_NONE;

    // shifter sees the latched operand and the carry as it stood at issue
    assign rotBus.op      = op_q;
    assign rotBus.operand = operand_q;
    assign rotBus.carryIn = flags_q[`FLAG_C];

    rotate_shifter u_shifter (
        .bus (rotBus)
    );

    // new flags: only C, Z, S and V move, D, H and the low bits are kept
    logic [7:0] rotFlags;
    always_comb begin
        rotFlags            = flags_q;
        rotFlags[`FLAG_C]   = rotBus.carryOut;
        rotFlags[`FLAG_Z]   = rotBus.zeroOut;
        rotFlags[`FLAG_S]   = rotBus.signOut;
        rotFlags[`FLAG_V]   = rotBus.overflowOut;
    end

    // stack pop helper
    logic        popDone;
    logic [15:0] popPc;
    logic [15:0] popSp;
    logic [15:0] popAddr;
    logic        popRead;
    wire         popStart = accept && isRet;

    stack_pop_unit u_pop (
        .core_clk         (core_clk),
        .reset_n          (reset_n),
        .start            (popStart),
        .stackPointerIn   (sp_q),
        .memData          (memReadData),
        .memAddr          (popAddr),
        .memRead          (popRead),
        .done             (popDone),
        .poppedPc         (popPc),
        .nextStackPointer (popSp)
    );

    // rotate timing: issue, operand read, then two write-state cycles; indirect adds the pointer read
    wire rotLast = (cyc_q == 3'(`ROTATE_CYCLES - 3));

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (accept && isRot) begin
                    state_d = isInd ? ST_POINTER : ST_OPERAND;
                end else if (accept && isRet) begin
                    state_d = ST_RETURN;
                end
            end
            ST_POINTER: begin
                state_d = ST_OPERAND;
            end
            ST_OPERAND: begin
                state_d = ST_WRITE;
            end
            ST_WRITE: begin
                if (rotLast) begin
                    state_d = ST_IDLE;
                end
            end
            ST_RETURN: begin
                if (popDone) begin
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // register file port: pointer read, operand read, then write back
    assign regRead = (state_q == ST_IDLE && accept && isRot) || (state_q == ST_POINTER);
    // in the pointer cycle the pointer value itself addresses the operand read
    wire   ptrCycle = (state_q == ST_POINTER);
    assign regAddr = (state_q == ST_IDLE) ? operandAddr :
                     ptrCycle             ? regReadData : addr_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            op_q       <= OP_NONE;
            indirect_q <= 1'b0;
            addr_q     <= 8'h00;
            flags_q    <= 8'h00;
        end else if (accept) begin
            op_q       <= decodedOp;
            indirect_q <= isInd;
            addr_q     <= operandAddr;
            flags_q    <= flagsIn;
        end else if (state_q == ST_POINTER) begin
            addr_q     <= regReadData;
        end
    end

    // operand arrives one cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            operand_q <= 8'h00;
        end else if (state_q == ST_OPERAND && !(indirect_q && regRead)) begin
            operand_q <= regReadData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cyc_q <= 3'd0;
        end else if (accept) begin
            cyc_q <= 3'd0;
        end else if (state_q == ST_WRITE) begin
            cyc_q <= cyc_q + 3'd1;
        end
    end

    // result and flags are captured in the first write cycle and written once, in the second
    wire writeNow = (state_q == ST_WRITE) && (cyc_q == 3'd0);

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            resultData_q <= 8'h00;
            flagsOut_q   <= 8'h00;
            regWrite_q   <= 1'b0;
            flagsWrite_q <= 1'b0;
        end else begin
            regWrite_q   <= writeNow;
            flagsWrite_q <= writeNow;
            if (writeNow) begin
                resultData_q <= rotBus.result;
                flagsOut_q   <= rotFlags;
            end
        end
    end

    // the pointer register itself is never rewritten; only addr_q is targeted
    assign regWrite     = regWrite_q;
    assign regWriteData = resultData_q;
    assign flagsWrite   = flagsWrite_q;
    assign flagsOut     = flagsOut_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pc_q <= `PC_RESET;
            sp_q <= `SP_RESET;
        end else if (popDone) begin
            pc_q <= popPc;
            sp_q <= popSp;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            illegal_q <= 1'b0;
        end else begin
            illegal_q <= issue && (state_q == ST_IDLE) && !isRot && !isRet;
        end
    end

    assign memAddr        = popAddr;
    assign memRead        = popRead;
    assign programCounter = pc_q;
    // the fetch strobe follows the pop, so it names the restored address
    assign fetchRequest   = (state_q == ST_FETCH);
    assign busy           = (state_q != ST_IDLE);
    assign illegalOpcode  = illegal_q;
    assign stackPointer   = sp_q;
endmodule

/* File: logic/rotate_return_params.svh */
// constants for the rotate and return execution unit
`ifndef ROTATE_RETURN_PARAMS_SVH
`define ROTATE_RETURN_PARAMS_SVH
`define OPC_RET          8'hAF
`define OPC_RL_DIR       8'h90
`define OPC_RL_IND       8'h91
`define OPC_RLC_DIR      8'h10
`define OPC_RLC_IND      8'h11
`define OPC_RR_DIR       8'hE0
`define OPC_RR_IND       8'hE1
`define OPC_RRC_DIR      8'hC0
`define OPC_RRC_IND      8'hC1
`define FLAG_C           7
`define FLAG_Z           6
`define FLAG_S           5
`define FLAG_V           4
`define FLAG_D           3
`define FLAG_H           2
`define SP_STEP          16'h0002
`define ROTATE_CYCLES    4
`define RETURN_CYCLES    8
`define PC_RESET         16'h0000
`define SP_RESET         16'h0000
`endif

/* File: logic/rotate_return_pkg.sv */
// types for the rotate and return execution unit
package rotate_return_pkg;
    typedef enum logic [4:0] {
        OP_NONE                  = 5'b00001,
        OP_ROTATE_LEFT           = 5'b00010,
        OP_ROTATE_LEFT_VIA_CARRY = 5'b00100,
        OP_ROTATE_RIGHT          = 5'b01000,
        OP_ROTATE_RIGHT_VIA_CARRY= 5'b10000
    } rotate_op_type;
endpackage

/* File: logic/rotate_bus_if.sv */
// interface carrying rotate requests and results between the unit and its shifter
`timescale 1ns/1ps
interface rotate_bus_if;
    import rotate_return_pkg::*;
    rotate_op_type op;
    logic [7:0]    operand;
    logic          carryIn;
    logic [7:0]    result;
    logic          carryOut;
    logic          zeroOut;
    logic          signOut;
    logic          overflowOut;
    modport requester (output op, operand, carryIn, input result, carryOut, zeroOut, signOut, overflowOut);
    modport shifter   (input op, operand, carryIn, output result, carryOut, zeroOut, signOut, overflowOut);
endinterface

/* File: logic/rotate_shifter.sv */
// combinational one-bit rotator with flag generation
`timescale 1ns/1ps
module rotate_shifter (
    rotate_bus_if.shifter bus
);
    import rotate_return_pkg::*;
    logic [7:0] res;
    logic       cy;
    always_comb begin
        res = bus.operand;
        cy  = bus.carryIn;
        unique case (bus.op)
            OP_NONE: begin
                res = bus.operand;
                cy  = bus.carryIn;
            end
            OP_ROTATE_LEFT: begin
                res = {bus.operand[6:0], bus.operand[7]};
                cy  = bus.operand[7];
            end
            OP_ROTATE_LEFT_VIA_CARRY: begin
                res = {bus.operand[6:0], bus.carryIn};
                cy  = bus.operand[7];
            end
            OP_ROTATE_RIGHT: begin
                res = {bus.operand[0], bus.operand[7:1]};
                cy  = bus.operand[0];
            end
            OP_ROTATE_RIGHT_VIA_CARRY: begin
                res = {bus.carryIn, bus.operand[7:1]};
                cy  = bus.operand[0];
            end
        endcase
    end
    assign bus.result      = res;
    assign bus.carryOut    = cy;
    assign bus.zeroOut     = (res == 8'h00);
    assign bus.signOut     = res[7];
    assign bus.overflowOut = res[7] ^ bus.operand[7];
endmodule

/* File: logic/stack_pop_unit.sv */
// pops a two-byte return address, high byte first, and advances the stack pointer
`timescale 1ns/1ps
`include "rotate_return_params.svh"
module stack_pop_unit (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        start,
    input  wire logic [15:0] stackPointerIn,
    input  wire logic [7:0]  memData,
    output logic      [15:0] memAddr,
    output logic             memRead,
    output logic             done,
    output logic      [15:0] poppedPc,
    output logic      [15:0] nextStackPointer
);
    logic [3:0]  count_q;
    logic [15:0] sp_q;
    logic [7:0]  hi_q;
    logic [7:0]  lo_q;
    wire         busy      = (count_q != 4'd0);
    wire         readHigh  = (count_q == 4'd1);
    wire         readLow   = (count_q == 4'd3);
    wire         takeHigh  = (count_q == 4'd2);
    wire         takeLow   = (count_q == 4'd4);
    wire         lastCycle = (count_q == 4'(`RETURN_CYCLES - 1));
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            count_q <= 4'd0;
            sp_q    <= 16'h0000;
            hi_q    <= 8'h00;
            lo_q    <= 8'h00;
        end else begin
            if (start && !busy) begin
                count_q <= 4'd1;
                sp_q    <= stackPointerIn;
            end else if (lastCycle) begin
                count_q <= 4'd0;
            end else if (busy) begin
                count_q <= count_q + 4'd1;
            end
            if (takeHigh) begin
                hi_q <= memData;
            end
            if (takeLow) begin
                lo_q <= memData;
            end
        end
    end
    assign memRead          = readHigh || readLow;
    assign memAddr          = readLow ? (sp_q + 16'h0001) : sp_q;
    assign done             = lastCycle;
    assign poppedPc         = {hi_q, lo_q};
    assign nextStackPointer = sp_q + `SP_STEP;
endmodule

/* File: bench/rotate_and_return_unit_chk.sv */
// concurrent checks on the ports of the rotate and return unit
`timescale 1ns/1ps
`include "rotate_return_params.svh"
module rotate_and_return_unit_chk (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        issue,
    input wire logic [7:0]  opcode,
    input wire logic [7:0]  operandAddr,
    input wire logic [7:0]  regReadData,
    input wire logic [7:0]  flagsIn,
    input wire logic [7:0]  memReadData,
    input wire logic [7:0]  regAddr,
    input wire logic        regRead,
    input wire logic        regWrite,
    input wire logic [7:0]  regWriteData,
    input wire logic        flagsWrite,
    input wire logic [7:0]  flagsOut,
    input wire logic [15:0] memAddr,
    input wire logic        memRead,
    input wire logic [15:0] programCounter,
    input wire logic [15:0] stackPointer,
    input wire logic        fetchRequest,
    input wire logic        busy,
    input wire logic        illegalOpcode
);
    logic [7:0]  startOp_q;
    logic [7:0]  startFlags_q;
    logic [15:0] startSp_q;
    wire         taken      = issue && !busy;
    wire         retStart   = taken && opcode == `OPC_RET;
    wire         rotStart   = taken && opcode inside {`OPC_RL_DIR, `OPC_RL_IND, `OPC_RLC_DIR, `OPC_RLC_IND,
                                                      `OPC_RR_DIR, `OPC_RR_IND, `OPC_RRC_DIR, `OPC_RRC_IND};
    wire         leftPlain  = startOp_q inside {`OPC_RL_DIR, `OPC_RL_IND};
    wire         leftCarry  = startOp_q inside {`OPC_RLC_DIR, `OPC_RLC_IND};
    wire         rightPlain = startOp_q inside {`OPC_RR_DIR, `OPC_RR_IND};
    // the old sign bit is recovered from the result or, for rotate left via carry, from the new carry flag, so no operand tap is needed
    wire         oldBit7    = leftPlain ? regWriteData[0] : leftCarry ? flagsOut[`FLAG_C] : regWriteData[6];

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            startOp_q    <= 8'h00;
            startFlags_q <= 8'h00;
            startSp_q    <= 16'h0000;
        end else if (taken) begin
            startOp_q    <= opcode;
            startFlags_q <= flagsIn;
            startSp_q    <= stackPointer;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_popHigh; memRead && memAddr == stackPointer; endsequence
    sequence s_popLow; memRead && memAddr == stackPointer + 16'h0001; endsequence
    property p_retPop; retStart |-> ##[1:2] s_popHigh ##2 s_popLow; endproperty
    property p_retSp; retStart |-> ##[8:11] (stackPointer == startSp_q + `SP_STEP); endproperty
    property p_retBusy; retStart |=> busy[*8]; endproperty
    property p_retFetch; retStart |-> ##[8:11] fetchRequest; endproperty
    property p_retQuiet; retStart |=> (!flagsWrite && !regWrite)[*8]; endproperty
    property p_rotBusy; rotStart |=> busy[*3]; endproperty
    property p_rotDone; rotStart |-> ##[4:7] !busy; endproperty
    property p_leftCarry; flagsWrite && leftPlain |-> flagsOut[`FLAG_C] == regWriteData[0]; endproperty
    property p_rightCarry; flagsWrite && rightPlain |-> flagsOut[`FLAG_C] == regWriteData[7]; endproperty
    property p_zeroSign;
        flagsWrite |-> flagsOut[`FLAG_Z] == (regWriteData == 8'h00) && flagsOut[`FLAG_S] == regWriteData[7];
    endproperty
    property p_overflow; flagsWrite |-> flagsOut[`FLAG_V] == (oldBit7 ^ regWriteData[7]); endproperty

    a_retPop: assert property (p_retPop) else $error("stack pop order wrong");
    a_retSp: assert property (p_retSp) else $error("stack pointer not advanced by two");
    a_retBusy: assert property (p_retBusy) else $error("return ended early");
    a_retFetch: assert property (p_retFetch) else $error("no fetch after return");
    a_retQuiet: assert property (p_retQuiet) else $error("return wrote flags or registers");
    a_rotBusy: assert property (p_rotBusy) else $error("rotate ended early");
    a_rotDone: assert property (p_rotDone) else $error("rotate ran too long");
    a_leftCarry: assert property (p_leftCarry) else $error("left carry wrong");
    a_rightCarry: assert property (p_rightCarry) else $error("right carry wrong");
    a_zeroSign: assert property (p_zeroSign) else $error("zero or sign flag wrong");
    a_overflow: assert property (p_overflow) else $error("overflow flag wrong");
endmodule

bind rotate_and_return_unit rotate_and_return_unit_chk chk_u (.core_clk, .reset_n, .issue, .opcode, .operandAddr,
    .regReadData, .flagsIn, .memReadData, .regAddr, .regRead, .regWrite, .regWriteData, .flagsWrite, .flagsOut,
    .memAddr, .memRead, .programCounter, .stackPointer, .fetchRequest, .busy, .illegalOpcode);

/* File: bench/rotate_and_return_unit_tb_top.sv */
// self-checking bench for the rotate and return unit
`timescale 1ns/1ps
`include "rotate_return_params.svh"
module rotate_and_return_unit_tb_top;
    logic        core_clk, reset_n, issue, regRead, regWrite, flagsWrite, memRead, fetchRequest, busy, illegalOpcode;
    logic [7:0]  opcode, operandAddr, regReadData, flagsIn, memReadData, regAddr, regWriteData, flagsOut;
    logic [15:0] memAddr, programCounter, stackPointer, pcAtFetch;
    logic [7:0]  regFile [0:255];
    logic [7:0]  stackMem [0:255];
    logic [7:0]  opList [0:7];
    int          errors, samples_checked, seed, fetchCount, illegalCount, writeCount;

    rotate_and_return_unit dut_u (.core_clk, .reset_n, .issue, .opcode, .operandAddr, .regReadData, .flagsIn,
        .memReadData, .regAddr, .regRead, .regWrite, .regWriteData, .flagsWrite, .flagsOut, .memAddr, .memRead,
        .programCounter, .stackPointer, .fetchRequest, .busy, .illegalOpcode);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // register file, flags register and stack answer one cycle after each strobe
    always @(posedge core_clk) begin
        if (regRead) regReadData <= regFile[regAddr];
        if (regWrite) regFile[regAddr] <= regWriteData;
        if (flagsWrite) flagsIn <= flagsOut;
        if (memRead) memReadData <= stackMem[memAddr[7:0]];
        if (fetchRequest) pcAtFetch <= programCounter;
        if (fetchRequest) fetchCount++;
        if (illegalOpcode) illegalCount++;
        if (regWrite || flagsWrite) writeCount++;
    end

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [15:0] rot_expect(input logic [7:0] op, input logic [7:0] v, input logic [7:0] fl);
        logic [7:0] r;
        logic [7:0] f;
        case (op)
            `OPC_RL_DIR, `OPC_RL_IND: r = {v[6:0], v[7]};
            `OPC_RLC_DIR, `OPC_RLC_IND: r = {v[6:0], fl[`FLAG_C]};
            `OPC_RR_DIR, `OPC_RR_IND: r = {v[0], v[7:1]};
            default: r = {fl[`FLAG_C], v[7:1]};
        endcase
        f = fl;
        f[`FLAG_C] = (op inside {`OPC_RL_DIR, `OPC_RL_IND, `OPC_RLC_DIR, `OPC_RLC_IND}) ? v[7] : v[0];
        f[`FLAG_Z] = (r == 8'h00);
        f[`FLAG_S] = r[7];
        f[`FLAG_V] = r[7] ^ v[7];
        return {r, f};
    endfunction

    // issue is dropped after one edge and the old fields scrambled, so nothing stale is reused
    task automatic run_op(input logic [7:0] op, input logic [7:0] addr, output int cycles);
        @(posedge core_clk);
        issue <= 1'b1;
        opcode <= op;
        operandAddr <= addr;
        @(posedge core_clk);
        issue <= 1'b0;
        opcode <= 8'($random(seed));
        operandAddr <= 8'($random(seed));
        cycles = 1;
        #1;
        while (busy !== 1'b0 && cycles < 20) begin
            @(posedge core_clk);
            #1;
            cycles++;
        end
    endtask

    task automatic do_rotate(input logic [7:0] op, input logic [7:0] v, input logic [7:0] fl);
        logic [7:0]  dst, ptr;
        logic [15:0] exp;
        int          cyc;
        dst = 8'($random(seed));
        ptr = dst ^ (8'($random(seed)) | 8'h01);
        exp = rot_expect(op, v, fl);
        @(posedge core_clk);
        regFile[dst] <= v;
        regFile[ptr] <= dst;
        flagsIn <= fl;
        run_op(op, op[0] ? ptr : dst, cyc);
        check(regFile[dst], exp[15:8], "rotate result");
        check(flagsIn, exp[7:0], "rotate flags");
        check(regFile[ptr], dst, "pointer kept");
        check(16'(cyc), 16'(`ROTATE_CYCLES + op[0]), "rotate length");
    endtask

    task automatic do_return();
        logic [15:0] sp, expPc;
        logic [7:0]  fl;
        int          cyc, fetches;
        sp = stackPointer;
        expPc = {stackMem[sp[7:0]], stackMem[sp[7:0] + 8'h01]};
        fl = flagsIn;
        fetches = fetchCount;
        run_op(`OPC_RET, 8'($random(seed)), cyc);
        check(programCounter, expPc, "return address");
        check(stackPointer, sp + `SP_STEP, "stack pointer");
        check(flagsIn, fl, "flags kept");
        check(pcAtFetch, expPc, "fetch address");
        check(16'(fetchCount - fetches), 16'h0001, "fetch count");
        check(16'(cyc), 16'(`RETURN_CYCLES + 1), "return length");
    endtask

    task automatic do_illegal(input logic [7:0] op);
        int ill, wr, cyc;
        ill = illegalCount;
        wr = writeCount;
        run_op(op, 8'h00, cyc);
        repeat (3) @(posedge core_clk);
        #1;
        check(16'(illegalCount - ill), 16'h0001, "illegal pulse");
        check(16'(writeCount - wr), 16'h0000, "illegal wrote");
    endtask

    initial begin
        #200000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        int         k;
        logic [7:0] corner [0:5];
        seed = 52129;
        {issue, opcode, operandAddr, flagsIn} = '0;
        {errors, samples_checked, fetchCount, illegalCount, writeCount} = '0;
        reset_n = 1'b0;
        pcAtFetch = 16'h0000;
        opList = '{`OPC_RL_DIR, `OPC_RL_IND, `OPC_RLC_DIR, `OPC_RLC_IND,
                   `OPC_RR_DIR, `OPC_RR_IND, `OPC_RRC_DIR, `OPC_RRC_IND};
        corner = '{8'h00, 8'h80, 8'h01, 8'hFF, 8'hAA, 8'h55};
        for (k = 0; k < 256; k++) begin
            regFile[k] = 8'($random(seed));
            stackMem[k] = 8'($random(seed));
        end
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        check(programCounter, `PC_RESET, "reset counter");
        check(stackPointer, `SP_RESET, "reset stack");
        // every opcode against every corner byte, with carry clear and then set
        for (k = 0; k < 96; k++) begin
            do_rotate(opList[k % 8], corner[(k / 8) % 6], {k > 47, 7'($random(seed))});
        end
        repeat (60) begin
            do_rotate(opList[$random(seed) & 7], 8'($random(seed)), 8'($random(seed)));
            if ($random(seed) & 1) do_return();
        end
        repeat (3) do_return();
        do_illegal(8'h00);
        do_illegal(8'h4F);
        do_illegal(8'hFF);
        do_illegal(8'h92);
        final_report();
    end
endmodule
